// ==== ioxm_pkg.sv ====
// package for the expander smbus manager: constants, operation codes and carrier types
// assumes a 250 MHz core clock and a byte-level smbus master outside this block
package ioxm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned UPDATE_PERIOD_MS  = 40;
  localparam int unsigned UPDATE_PERIOD_CYC = (UPDATE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // expander command registers
  // ----------------------------------------------------------------
  localparam logic [7:0] EXP_REG_IN0  = 8'h00;
  localparam logic [7:0] EXP_REG_OUT0 = 8'h02;
  localparam logic [7:0] EXP_REG_POL0 = 8'h04;
  localparam logic [7:0] EXP_REG_DIR0 = 8'h06;
  localparam logic [7:0] POL_NONE     = 8'h00;
  localparam logic [7:0] DIR_ALL_OUT  = 8'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  ADDR_RST   = 7'h00;
  localparam logic [15:0] VIEW_RST   = 16'h0000;
  localparam logic [15:0] OUT_RST    = 16'hffff;
  localparam logic [2:0]  STATUS_RST = 3'h0;

  typedef enum logic [1:0] {
    IOXM_OP_NONE,
    IOXM_OP_WRITE,
    IOXM_OP_READ
  } ioxm_op_t;

  // one byte-pair transaction handed to the smbus master
  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [7:0] data;
  } ioxm_req_t;

  // answer from the smbus master
  typedef struct packed {
    logic       done;
    logic       nack;
    logic       arb_lost;
    logic [7:0] rdata;
  } ioxm_rsp_t;

endpackage

// ==== ioxm_rr_arb.sv ====
// round-robin arbiter over expander requests
// assumes requests hold until granted; grant is one-hot, taken by caller on load
`timescale 1ns/1ns
`default_nettype none
module ioxm_rr_arb #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // request and grant
  input  wire logic [N-1:0] req,
  input  wire logic         load,
  output logic      [N-1:0] gnt
);

  logic [N-1:0] last;
  logic [N-1:0] next_last;

  // rotate search start past the last winner so every requester waits at most N-1 turns
  always_comb begin
    int unsigned idx;
    idx       = 0;
    gnt       = '0;
    next_last = last;
    for (int k = 1; k <= N; k++) begin
      idx = 0;
      for (int j = 0; j < N; j++) begin
        if (last[j]) begin
          idx = (j + k) % N;
        end
      end
      if (req[idx] && gnt == '0) begin
        gnt[idx] = 1'b1;
      end
    end
    if (load && gnt != '0) begin
      next_last = gnt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last <= {1'b1, {(N-1){1'b0}}};
    end else begin
      last <= next_last;
    end
  end

endmodule
`default_nettype wire

// ==== ioxm_top.sv ====
// expander smbus manager: keeps external 16-bit expanders in step with internal signals
// assumes an smbus byte master outside; expander interrupts arrive asynchronously
// Behaviour
// - link-status config first writes link-up states to expander register 2.
// - then writes link-activity states to expander register 3.
// - then writes zero to registers 4 and 5, no polarity inversion.
// - then writes registers 6 and 7 making all sixteen pins outputs.
// - while enabled, any difference between pins and internal view starts a transaction.
// - hot reset restoring defaults is a mismatch; restored outputs are written.
// - an internal output change causes a master smbus write.
// - outputs of one expander update at most once per 40 ms; config and reload writes skip this limit.
// - an asserted expander interrupt causes a master smbus read of inputs.
// - inputs of one expander read at most once per 40 ms; reload reads skip this limit.
// - pending expander transactions are arbitrated fairly, round robin.
// - errors during expander transactions are recorded in smbus status bits.
// - select field chooses the expander the debug fields act on.
// - signal view returns current input and output view of selected expander.
// - reload writes then reads selected expander and refreshes signal view.
// - link status and activity pins are driven low for indicator on.
// - no expander transaction before eeprom initialization completes.
// - writing an expander address starts that expander's configuration writes.
`timescale 1ns/1ns
`default_nettype none
module ioxm_top
  import ioxm_pkg::*;
#(
  parameter int          N_EXP      = 4,
  parameter int unsigned UPDATE_CYC = UPDATE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                SRST,
  // internal signal state
  input  wire logic                EEPROM_INIT_DONE,
  input  wire logic [N_EXP-1:0]    EXP_ENABLE,
  input  wire logic [N_EXP-1:0]    EXP_IS_LINK,
  input  wire logic [N_EXP*16-1:0] EXP_OUT_STATE,
  input  wire logic [7:0]          LINK_UP,
  input  wire logic [7:0]          LINK_ACTIVE,
  input  wire logic [N_EXP-1:0]    EXP_INT_N,
  // address configuration
  input  wire logic                EXP_ADDR_WR,
  input  wire logic [1:0]          EXP_ADDR_SEL,
  input  wire logic [6:0]          EXPANDER_BUS_ADDRESS,
  // debug interface
  input  wire logic [1:0]          EXPANDER_SELECT,
  input  wire logic                EXPANDER_RELOAD,
  output logic      [31:0]         EXPANDER_SIGNAL_VIEW,
  output logic      [N_EXP*16-1:0] EXP_IN_STATE,
  // status
  input  wire logic                SMBUS_STATUS_CLR,
  output logic      [2:0]          SMBUS_STATUS_REG,
  // smbus master
  output ioxm_req_t                SMB_REQ,
  output logic                     SMB_REQ_VALID,
  input  wire logic                SMB_REQ_READY,
  input  wire ioxm_rsp_t           SMB_RSP
);

  // ----------------------------------------------------------------
  // interrupt synchronisers
  // ----------------------------------------------------------------
  logic [N_EXP-1:0] int_meta;
  logic [N_EXP-1:0] int_sync;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      int_meta <= '1;
      int_sync <= '1;
    end else begin
      int_meta <= EXP_INT_N;
      int_sync <= int_meta;
    end
  end

  // ----------------------------------------------------------------
  // per-expander state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOXM_IDLE,
    IOXM_ISSUE,
    IOXM_WAIT
  } ioxm_state_t;

  logic [6:0]  addr      [N_EXP];
  logic [15:0] wr_val    [N_EXP];
  logic [15:0] rd_val    [N_EXP];
  logic [31:0] timer_w   [N_EXP];
  logic [31:0] timer_r   [N_EXP];
  logic [N_EXP-1:0] cfg_pend;
  logic [N_EXP-1:0] rd_pend;
  logic [N_EXP-1:0] reload_pend;
  logic [6:0]  next_addr    [N_EXP];
  logic [15:0] next_wr_val  [N_EXP];
  logic [15:0] next_rd_val  [N_EXP];
  logic [31:0] next_timer_w [N_EXP];
  logic [31:0] next_timer_r [N_EXP];
  logic [N_EXP-1:0] next_cfg_pend;
  logic [N_EXP-1:0] next_rd_pend;
  logic [N_EXP-1:0] next_reload_pend;

  ioxm_state_t state;
  ioxm_state_t next_state;
  logic        busy_d;
  logic        next_busy_d;
  logic [N_EXP-1:0] cur;
  logic [N_EXP-1:0] next_cur;
  logic [3:0]  step;
  logic [3:0]  next_step;
  logic [3:0]  last_step;
  logic [3:0]  next_last_step;
  logic [1:0]  kind;
  logic [1:0]  next_kind;
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [31:0] view;
  logic [31:0] next_view;
  ioxm_req_t   req;
  ioxm_req_t   next_req;

  // desired output word; link expander gets active-low led drive
  function automatic logic [15:0] want_out(input int e);
    if (EXP_IS_LINK[e]) begin
      return ~{LINK_ACTIVE, LINK_UP};
    end
    return EXP_OUT_STATE[e*16 +: 16];
  endfunction

  logic [N_EXP-1:0] need;
  logic [N_EXP-1:0] wr_need;
  logic [N_EXP-1:0] gnt;
  logic             arb_load;

  always_comb begin
    for (int e = 0; e < N_EXP; e++) begin
      // mismatch after hot reset is seen the same way as any output change
      wr_need[e] = EXP_ENABLE[e] && (want_out(e) != wr_val[e]) && timer_w[e] == 0;
      need[e]    = EEPROM_INIT_DONE && (cfg_pend[e] || reload_pend[e] || wr_need[e]
                   || (rd_pend[e] && timer_r[e] == 0 && EXP_ENABLE[e]));
    end
  end

  assign arb_load = (state == IOXM_IDLE) && (need != '0);

  ioxm_rr_arb #(
    .N(N_EXP)
  ) u_arb (
    .clk (CLK_SYS),
    .srst(SRST),
    .req (need),
    .load(arb_load),
    .gnt (gnt)
  );

  function automatic int onehot_idx(input logic [N_EXP-1:0] v);
    int r;
    r = 0;
    for (int i = 0; i < N_EXP; i++) begin
      if (v[i]) begin
        r = i;
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    int c;
    logic [15:0] w;
    c = onehot_idx(cur);
    w = want_out(c);
    next_state       = state;
    next_cur         = cur;
    next_step        = step;
    next_last_step   = last_step;
    next_kind        = kind;
    next_status      = status;
    next_view        = view;
    next_req         = req;
    next_addr        = addr;
    next_wr_val      = wr_val;
    next_rd_val      = rd_val;
    next_cfg_pend    = cfg_pend;
    next_rd_pend     = rd_pend;
    next_reload_pend = reload_pend;
    next_busy_d      = (state != IOXM_IDLE);
    for (int e = 0; e < N_EXP; e++) begin
      next_timer_w[e] = (timer_w[e] != 0) ? timer_w[e] - 1 : 32'h0000_0000;
      next_timer_r[e] = (timer_r[e] != 0) ? timer_r[e] - 1 : 32'h0000_0000;
      // interrupt release lags the read by the synchroniser: ignore it while served
      if (!int_sync[e] && !(cur[e] && (state != IOXM_IDLE || busy_d))) begin
        next_rd_pend[e] = 1'b1;
      end
    end
    if (EXP_ADDR_WR) begin
      next_addr[EXP_ADDR_SEL]     = EXPANDER_BUS_ADDRESS;
      next_cfg_pend[EXP_ADDR_SEL] = 1'b1;
    end
    if (SMBUS_STATUS_CLR) begin
      next_status = STATUS_RST;
    end
    case (state)
      IOXM_IDLE: begin
        if (arb_load) begin
          c        = onehot_idx(gnt);
          next_cur = gnt;
          if (cfg_pend[c]) begin
            next_kind = 2'd0;
            next_step = 4'd0;
            next_last_step = 4'd7;
          end else if (reload_pend[c]) begin
            next_kind = 2'd1;
            next_step = 4'd0;
            next_last_step = 4'd3;
          end else if (wr_need[c]) begin
            next_kind = 2'd2;
            next_step = 4'd0;
            next_last_step = 4'd1;
          end else begin
            next_kind = 2'd3;
            next_step = 4'd2;
            next_last_step = 4'd3;
          end
          next_state = IOXM_ISSUE;
        end
      end
      IOXM_ISSUE: begin
        next_req.addr = addr[c];
        next_req.rd   = 1'b0;
        case (step)
          4'd0: begin
            next_req.cmd  = EXP_REG_OUT0;
            next_req.data = w[7:0];
          end
          4'd1: begin
            next_req.cmd  = EXP_REG_OUT0 + 8'h01;
            next_req.data = w[15:8];
          end
          4'd2: begin
            next_req.cmd = EXP_REG_IN0;
            next_req.rd  = 1'b1;
          end
          4'd3: begin
            next_req.cmd = EXP_REG_IN0 + 8'h01;
            next_req.rd  = 1'b1;
          end
          4'd4: begin
            next_req.cmd  = EXP_REG_POL0;
            next_req.data = POL_NONE;
          end
          4'd5: begin
            next_req.cmd  = EXP_REG_POL0 + 8'h01;
            next_req.data = POL_NONE;
          end
          4'd6: begin
            next_req.cmd  = EXP_REG_DIR0;
            next_req.data = DIR_ALL_OUT;
          end
          default: begin
            next_req.cmd  = EXP_REG_DIR0 + 8'h01;
            next_req.data = DIR_ALL_OUT;
          end
        endcase
        if (step == 4'd0) begin
          next_wr_val[c]  = w;
          next_timer_w[c] = UPDATE_CYC;
        end
        if (step == 4'd2) begin
          next_rd_pend[c] = 1'b0;
          next_timer_r[c] = UPDATE_CYC;
        end
        next_state = IOXM_WAIT;
      end
      IOXM_WAIT: begin
        if (SMB_RSP.done) begin
          if (SMB_RSP.nack || SMB_RSP.arb_lost) begin
            next_status = next_status | {1'b1, SMB_RSP.arb_lost, SMB_RSP.nack};
          end
          if (step == 4'd2) begin
            next_rd_val[c][7:0] = SMB_RSP.rdata;
          end
          if (step == 4'd3) begin
            next_rd_val[c][15:8] = SMB_RSP.rdata;
          end
          // config order: 0,1,4,5,6,7 then stop; others run step..last
          if (step == last_step) begin
            next_state = IOXM_IDLE;
            if (kind == 2'd0) begin
              next_cfg_pend[c] = 1'b0;
            end
            if (kind == 2'd1) begin
              next_reload_pend[c] = 1'b0;
            end
          end else begin
            next_step  = (kind == 2'd0 && step == 4'd1) ? 4'd4 : step + 4'd1;
            next_state = IOXM_ISSUE;
          end
        end
      end
      default: begin
        next_state = IOXM_IDLE;
      end
    endcase
    // debug view follows the selected expander; reload refreshes rd_val
    next_view = {rd_val[EXPANDER_SELECT], wr_val[EXPANDER_SELECT]};
    // late sets win over a same-cycle clear at the end of a sequence
    if (EXP_ADDR_WR) begin
      next_cfg_pend[EXP_ADDR_SEL] = 1'b1;
    end
    if (EXPANDER_RELOAD) begin
      next_reload_pend[EXPANDER_SELECT] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state       <= IOXM_IDLE;
      busy_d      <= 1'b0;
      cur         <= '0;
      step        <= 4'h0;
      last_step   <= 4'h0;
      kind        <= 2'h0;
      status      <= STATUS_RST;
      view        <= 32'h0000_0000;
      req         <= '0;
      cfg_pend    <= '0;
      rd_pend     <= '0;
      reload_pend <= '0;
      for (int e = 0; e < N_EXP; e++) begin
        addr[e]    <= ADDR_RST;
        wr_val[e]  <= OUT_RST;
        rd_val[e]  <= VIEW_RST;
        timer_w[e] <= 32'h0000_0000;
        timer_r[e] <= 32'h0000_0000;
      end
    end else begin
      state       <= next_state;
      busy_d      <= next_busy_d;
      cur         <= next_cur;
      step        <= next_step;
      last_step   <= next_last_step;
      kind        <= next_kind;
      status      <= next_status;
      view        <= next_view;
      req         <= next_req;
      cfg_pend    <= next_cfg_pend;
      rd_pend     <= next_rd_pend;
      reload_pend <= next_reload_pend;
      addr        <= next_addr;
      wr_val      <= next_wr_val;
      rd_val      <= next_rd_val;
      timer_w     <= next_timer_w;
      timer_r     <= next_timer_r;
    end
  end

  assign SMB_REQ              = req;
  assign SMB_REQ_VALID        = (state == IOXM_WAIT) && SMB_REQ_READY;
  assign SMBUS_STATUS_REG     = status;
  assign EXPANDER_SIGNAL_VIEW = view;
  always_comb begin
    for (int e = 0; e < N_EXP; e++) begin
      EXP_IN_STATE[e*16 +: 16] = rd_val[e];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_idle_start;
    state == IOXM_IDLE && arb_load;
  endsequence

  a_no_early_txn: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !EEPROM_INIT_DONE |-> state == IOXM_IDLE || $past(EEPROM_INIT_DONE))
    else $error("transaction began before eeprom init");
  a_start_issue: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_idle_start |=> state == IOXM_ISSUE)
    else $error("granted request did not issue");
  a_one_grant: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $onehot0(gnt))
    else $error("multiple grants");
  a_wait_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
    state == IOXM_WAIT && !SMB_RSP.done |=> state == IOXM_WAIT)
    else $error("left wait before done");
  a_err_record: assert property (@(posedge CLK_SYS) disable iff (SRST)
    state == IOXM_WAIT && SMB_RSP.done && SMB_RSP.nack && !SMBUS_STATUS_CLR
    |=> status[0] && status[2])
    else $error("nack not recorded");
  a_write_rate: assert property (@(posedge CLK_SYS) disable iff (SRST)
    state == IOXM_ISSUE && step == 4'd0 |=> timer_w[onehot_idx(cur)] == UPDATE_CYC)
    else $error("update period not armed");
  a_read_rate: assert property (@(posedge CLK_SYS) disable iff (SRST)
    state == IOXM_ISSUE && step == 4'd2 |=> timer_r[onehot_idx(cur)] == UPDATE_CYC)
    else $error("read period not armed");
  a_cfg_pend: assert property (@(posedge CLK_SYS) disable iff (SRST)
    EXP_ADDR_WR |=> cfg_pend[$past(EXP_ADDR_SEL)])
    else $error("address write did not queue config");
  a_view_sel: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $stable(EXPANDER_SELECT) ##1 $stable(EXPANDER_SELECT)
    |-> view[15:0] == $past(wr_val[EXPANDER_SELECT]))
    else $error("signal view mismatch");

endmodule
`default_nettype wire

// ==== ioxm_smb_model.sv ====
// behavioural smbus byte master with 16-bit expanders behind it
// assumes expander n answers at address BASE+n; pins are set by the bench
`timescale 1ns/1ns
`default_nettype none
module ioxm_smb_model
  import ioxm_pkg::*;
#(
  parameter int         N    = 4,
  parameter logic [6:0] BASE = 7'h20
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           srst,
  // request side
  input  wire ioxm_req_t      req,
  input  wire logic           req_valid,
  output logic                req_ready,
  output ioxm_rsp_t           rsp,
  // expander pins and interrupts
  output logic      [N-1:0]   int_n,
  input  wire logic [N*16-1:0] pins,
  // behaviour control
  input  wire logic           slow,
  input  wire logic           nack_en
);
  ioxm_req_t       log_q[$];
  int              cyc_q[$];
  int              cyc;
  int              cnt;
  logic            busy;
  ioxm_req_t       cur;
  logic [N*16-1:0] last;

  // ----------------------------------------------------------------
  // transaction engine
  // ----------------------------------------------------------------
  // done still high blocks a new accept: the design leaves its wait state one edge later
  always_ff @(posedge clk) begin
    cyc <= cyc + 1;
    rsp.done <= 1'b0;
    rsp.rdata <= ~rsp.rdata;
    if (srst) begin
      busy <= 1'b0;
      last <= '0;
      rsp <= '0;
      req_ready <= 1'b1;
    end else begin
      req_ready <= slow ? cyc[2] : 1'b1;
      if (!busy && req_valid && !rsp.done) begin
        busy <= 1'b1;
        cur <= req;
        cnt <= slow ? 8 : 2;
        log_q.push_back(req);
        cyc_q.push_back(cyc);
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        rsp.done <= 1'b1;
        rsp.nack <= nack_en;
        rsp.arb_lost <= 1'b0;
        if (cur.rd) begin
          rsp.rdata <= pins[(cur.addr - BASE) * 16 + cur.cmd[0] * 8 +: 8];
          last[(cur.addr - BASE) * 16 + cur.cmd[0] * 8 +: 8] <=
            pins[(cur.addr - BASE) * 16 + cur.cmd[0] * 8 +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain interrupts, pulled up when released
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N; i++) begin
      int_n[i] = (pins[i*16 +: 16] === last[i*16 +: 16]);
    end
  end
endmodule
`default_nettype wire

// ==== test_ioxm_top.sv ====
// self-checking bench for the expander smbus manager
// assumes expander 0 carries link leds at 7'h20, expander 1 plain outputs at 7'h21
`timescale 1ns/1ns
`default_nettype none
module test_ioxm_top;
  import ioxm_pkg::*;
  localparam int UPD = 200;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic init_done = 1'b0, addr_wr = 1'b0, reload = 1'b0, st_clr = 1'b0;
  logic slow = 1'b0, nack_en = 1'b0, ready;
  logic [1:0] addr_sel = 2'h0, sel = 2'h0;
  logic [6:0] bus_addr = 7'h00;
  logic [7:0] link_up = 8'h5a, link_act = 8'h0f;
  logic [63:0] out_state = 64'h0000_0000_1234_0000, pins = '0, in_state;
  logic [3:0] int_n;
  logic [31:0] view;
  logic [2:0] status;
  logic req_valid;
  ioxm_req_t req;
  ioxm_rsp_t rsp;
  int fail_count = 0, checked = 0, last_cyc, ref_cyc;

  always #2 clk_sys = ~clk_sys;

  ioxm_top #(.N_EXP(4), .UPDATE_CYC(UPD)) i_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .EEPROM_INIT_DONE(init_done),
    .EXP_ENABLE(4'h3), .EXP_IS_LINK(4'h1), .EXP_OUT_STATE(out_state),
    .LINK_UP(link_up), .LINK_ACTIVE(link_act), .EXP_INT_N(int_n),
    .EXP_ADDR_WR(addr_wr), .EXP_ADDR_SEL(addr_sel), .EXPANDER_BUS_ADDRESS(bus_addr),
    .EXPANDER_SELECT(sel), .EXPANDER_RELOAD(reload), .EXPANDER_SIGNAL_VIEW(view),
    .EXP_IN_STATE(in_state), .SMBUS_STATUS_CLR(st_clr), .SMBUS_STATUS_REG(status),
    .SMB_REQ(req), .SMB_REQ_VALID(req_valid), .SMB_REQ_READY(ready), .SMB_RSP(rsp));

  ioxm_smb_model #(.N(4), .BASE(7'h20)) m (
    .clk(clk_sys), .srst(srst), .req(req), .req_valid(req_valid), .req_ready(ready),
    .rsp(rsp), .int_n(int_n), .pins(pins), .slow(slow), .nack_en(nack_en));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // pops the next bus transaction; a missing one shows as a mismatch
  task automatic expect_txn(input logic rd, input logic [6:0] a, input logic [7:0] c,
                            input logic [7:0] d, input logic chk_data);
    ioxm_req_t t;
    int n;
    n = 0;
    while (m.log_q.size() == 0 && n < 3 * UPD + 400) begin
      tick(1);
      n++;
    end
    if (m.log_q.size() == 0) begin
      check(32'h0, 32'h1);
    end else begin
      t = m.log_q.pop_front();
      last_cyc = m.cyc_q.pop_front();
      if (!chk_data) t.data = d;
      check({8'h00, t}, {8'h00, rd, a, c, d});
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_config;
    addr_sel = 2'h0;
    bus_addr = 7'h20;
    pulse(addr_wr);
    addr_sel = 2'h1;
    bus_addr = 7'h21;
    pulse(addr_wr);
    tick(50);
    check(m.log_q.size(), 0);
    init_done = 1'b1;
    expect_txn(1'b0, 7'h20, EXP_REG_OUT0, ~link_up, 1'b1);
    expect_txn(1'b0, 7'h20, 8'h03, ~link_act, 1'b1);
    expect_txn(1'b0, 7'h20, EXP_REG_POL0, POL_NONE, 1'b1);
    expect_txn(1'b0, 7'h20, 8'h05, POL_NONE, 1'b1);
    expect_txn(1'b0, 7'h20, EXP_REG_DIR0, DIR_ALL_OUT, 1'b1);
    expect_txn(1'b0, 7'h20, 8'h07, DIR_ALL_OUT, 1'b1);
    expect_txn(1'b0, 7'h21, 8'h02, 8'h34, 1'b1);
    expect_txn(1'b0, 7'h21, 8'h03, 8'h12, 1'b1);
    for (int r = 4; r < 8; r++) begin
      expect_txn(1'b0, 7'h21, r[7:0], 8'h00, 1'b1);
    end
  endtask

  task automatic t_update;
    out_state[31:16] = 16'h5678;
    expect_txn(1'b0, 7'h21, 8'h02, 8'h78, 1'b1);
    ref_cyc = last_cyc;
    expect_txn(1'b0, 7'h21, 8'h03, 8'h56, 1'b1);
    out_state[31:16] = 16'h9abc;
    expect_txn(1'b0, 7'h21, 8'h02, 8'hbc, 1'b1);
    check(last_cyc - ref_cyc >= UPD - 4, 1);
    expect_txn(1'b0, 7'h21, 8'h03, 8'h9a, 1'b1);
  endtask

  task automatic t_interrupt;
    slow = 1'b1;
    pins[31:16] = 16'hbeef;
    expect_txn(1'b1, 7'h21, EXP_REG_IN0, 8'h00, 1'b0);
    expect_txn(1'b1, 7'h21, 8'h01, 8'h00, 1'b0);
    tick(20);
    check(int_n[1], 1'b1);
    check(in_state[31:16], 16'hbeef);
    sel = 2'h1;
    tick(2);
    check(view, 32'hbeef_9abc);
    slow = 1'b0;
  endtask

  task automatic t_reload;
    sel = 2'h0;
    tick(1);
    pulse(reload);
    expect_txn(1'b0, 7'h20, 8'h02, ~link_up, 1'b1);
    expect_txn(1'b0, 7'h20, 8'h03, ~link_act, 1'b1);
    expect_txn(1'b1, 7'h20, 8'h00, 8'h00, 1'b0);
    expect_txn(1'b1, 7'h20, 8'h01, 8'h00, 1'b0);
    tick(20);
    check(view, {16'h0000, ~link_act, ~link_up});
  endtask

  task automatic t_error;
    nack_en = 1'b1;
    check(status, STATUS_RST);
    link_up = 8'h00;
    expect_txn(1'b0, 7'h20, 8'h02, 8'hff, 1'b1);
    tick(20);
    check(status, 3'h5);
    nack_en = 1'b0;
    pulse(st_clr);
    tick(1);
    check(status, 3'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    srst = 1'b0;
    tick(2);
    t_config();
    t_update();
    t_interrupt();
    t_reload();
    t_error();
    end_of_test();
  end

  // covers about 250 update periods of traffic with margin
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
